// File: rtl/tlrs_pkg.sv
// Constants, register map and carrier types of the test loop and restart supervisor.
// Assumes a single 40 MHz reference clock and an AHB-Lite register bus.
package tlrs_pkg;

    // Reference clock rate and the one-second time base derived from it.
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYCLES = TICK_S * CLK_HZ;
    // Length of one error indicator flash.
    localparam int unsigned FLASH_MS = 100;
    localparam int unsigned FLASH_CYCLES = FLASH_MS * (CLK_HZ / 1000);

    // Restart and pattern timeouts, in seconds.
    typedef logic [5:0] tlrs_sec_t;
    localparam tlrs_sec_t RESTART_STARTUP_S = 6'h32;
    localparam tlrs_sec_t RESTART_DATA_S = 6'h04;
    localparam tlrs_sec_t RESTART_PATTERN_S = 6'h3C;
    localparam tlrs_sec_t RESTART_RDL_S = 6'h3C;
    localparam tlrs_sec_t PAT_TIMEOUT_S = 6'h2D;

    // Pattern generator seed; any non-zero value works.
    localparam logic [8:0] PRBS_SEED = 9'h1FF;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ERRCNT = 8'h08;
    localparam logic [15:0] ERRCNT_RST = 16'h0000;

    typedef enum logic [1:0] {LOOP_NONE, LOOP_M1, LOOP_M2} tlrs_loop_e;
    typedef enum logic {LINK_STARTUP, LINK_DATA} tlrs_link_e;

    // Control register: bit 0 loop request, bit 1 pattern request, bit 2 error injection.
    typedef struct packed {
        logic inject;
        logic pat_req;
        logic loop_req;
    } tlrs_ctrl_s;
    localparam tlrs_ctrl_s CTRL_RST = 3'h0;

    // Status register, low bits upward: link up, loop mode, pattern running, timed out,
    // test mode, remote end of a remote digital loop.
    typedef struct packed {
        logic rdl_remote;
        logic test_mode;
        logic pat_timed_out;
        logic pat_active;
        tlrs_loop_e loop_mode;
        logic link_up;
    } tlrs_status_s;

endpackage : tlrs_pkg

// File: rtl/tlrs_top.sv
// Test loop and restart supervisor of a point-to-point line modem.
// Assumes one bit per ref_clk on every data pin, synchronous inputs and an AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - While framed packets arrive, assert clear-to-send and carrier detect.
// R2 - Without framed packets drop both; restart supervision uses this framing status.
// R3 - In data mode restart after 4 s of continuous unframed reception.
// R4 - Count only consecutive unframed seconds; start-up restarts after 50 s.
// R5 - While the local pattern generator runs, restart timeout becomes 60 s.
// R6 - Pattern generator stops 45 s after start, restoring the normal path.
// R7 - After pattern timeout blink error indicator until pattern switch returns.
// R8 - As remote end of a remote digital loop, restart timeout is 60 s.
// R9 - Test pattern goes to the line unframed, after the framer.
// R10 - Local loop returns data toward the local DTE.
// R11 - Remote loop returns line data to line and also passes it on.
// R12 - Local loop request gives mode 1 if link down, mode 2 if up.
// R13 - Test modes start from front-panel switches or DTE requests alike.
// R14 - Mode 1 loops inside the processor; line data is invalid.
// R15 - Releasing mode 1 leaves the unit in start-up to relink.
// R16 - Mode 2 loops local data in framer, far-end data in controller.
// R17 - Releasing mode 2 returns to data mode with normal paths.
// R18 - Mode 1 with pattern loops generator output into the local detector.
// R19 - Mode 1 with pattern sends no pattern data to the DTE.
// R20 - In mode 2 the local pattern generator is unavailable.
// R21 - Error indicator flashes per CRC error, or per pattern bit error.
// R22 - Test-mode indicator lights whenever any test mode is active.
// R23 - A one-second time base drives restart and pattern timers.
module tlrs_top
    import tlrs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
    parameter int unsigned FLASH_CYCLES_P = FLASH_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic frame_ok,
    input wire logic crc_err,
    input wire logic sw_local_loop,
    input wire logic sw_pattern,
    input wire logic dte_local_loop_req,
    input wire logic dte_pattern_req,
    input wire logic remote_digital_loop,
    input wire logic dte_td_bit,
    input wire logic framer_tx_bit,
    input wire logic framer_rd_bit,
    input wire logic line_rx_bit,
    output logic line_tx_bit,
    output logic dte_rd_bit,
    output logic framer_rx_bit,
    output logic framer_dte_loop,
    output logic cts,
    output logic cd,
    output logic line_restart,
    output logic no_signal_indicator,
    output logic error_indicator,
    output logic test_mode_indicator
);

    // Bus interface.
    tlrs_ctrl_s ctrl_reg;
    tlrs_ctrl_s ctrl_next;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_reg;
    logic [15:0] errcnt_reg;
    logic [15:0] errcnt_next;
    // Supervisor state.
    tlrs_link_e link_reg;
    tlrs_link_e link_next;
    tlrs_loop_e loop_reg;
    tlrs_loop_e loop_next;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    tlrs_sec_t unfr_sec_reg;
    tlrs_sec_t pat_sec_reg;
    logic pat_active_reg;
    logic pat_timed_out_reg;
    logic loop_req_d_reg;
    logic pat_req_d_reg;
    logic restart_reg;
    logic cts_reg;
    logic [8:0] gen_sr_reg;
    logic [8:0] det_sr_reg;
    logic [3:0] det_fill_reg;
    logic [31:0] flash_cnt_reg;
    logic blink_reg;
    logic err_ind_reg;
    logic tm_reg;
    logic line_tx_reg;
    logic dte_rd_reg;
    logic framer_rx_reg;
    logic fr_loop_reg;

    // Bus decode.
    wire bus_take = hsel && hready && htrans[1];
    wire rd_take = bus_take && !hwrite;
    wire wr_take = bus_take && hwrite;
    wire [7:0] take_addr = haddr[7:0];
    wire wr_ctrl = wr_pend_reg && (wr_addr_reg == ADDR_CTRL);
    wire wr_errcnt = wr_pend_reg && (wr_addr_reg == ADDR_ERRCNT);

    // R13 switch or DTE
    wire loop_req = sw_local_loop || dte_local_loop_req || ctrl_reg.loop_req;
    wire pat_req = sw_pattern || dte_pattern_req || ctrl_reg.pat_req;
    wire loop_rise = loop_req && !loop_req_d_reg;
    // R20 no generator in mode 2
    wire pat_start = pat_req && !pat_req_d_reg && (loop_reg != LOOP_M2) && !pat_timed_out_reg;

    tlrs_status_s status;
    assign status = '{rdl_remote: remote_digital_loop, test_mode: tm_reg,
                      pat_timed_out: pat_timed_out_reg, pat_active: pat_active_reg,
                      loop_mode: loop_reg, link_up: (link_reg == LINK_DATA)};

    wire [31:0] rd_mux = (take_addr == ADDR_CTRL) ? {29'h0000_0000, ctrl_reg} :
                         (take_addr == ADDR_STATUS) ? {25'h000_0000, status} :
                         (take_addr == ADDR_ERRCNT) ? {16'h0000, errcnt_reg} : 32'h0000_0000;

    // R4 start-up limit
    // R5 pattern limit
    // R8 remote-end limit
    // R3 data mode limit
    wire tlrs_sec_t restart_limit = pat_active_reg ? RESTART_PATTERN_S :
                                    remote_digital_loop ? RESTART_RDL_S :
                                    (link_reg == LINK_STARTUP) ? RESTART_STARTUP_S :
                                    RESTART_DATA_S;
    // R2 unframed time judges the link
    wire restart_now = tick_reg && !frame_ok && (unfr_sec_reg == restart_limit - 6'h01);

    // R9 pattern inserted after framer
    wire [8:0] gen_next = {gen_sr_reg[7:0], gen_sr_reg[8] ^ gen_sr_reg[4]};
    wire gen_bit = gen_sr_reg[8] ^ (ctrl_reg.inject && tick_reg);
    // R18 mode 1 pattern back to detector
    wire det_in = (loop_reg == LOOP_M1) ? gen_bit : line_rx_bit;
    wire det_err = pat_active_reg && (det_fill_reg == 4'h9) &&
                   (det_in != (det_sr_reg[8] ^ det_sr_reg[4]));
    // R21 flash per error event
    wire flash_evt = det_err || (crc_err && !pat_active_reg);

    // R11 remote loop returns line data
    // R16 far-end data returned here
    wire line_tx_next = (remote_digital_loop || loop_reg == LOOP_M2) ? line_rx_bit :
                        (pat_active_reg && loop_reg == LOOP_NONE) ? gen_bit : framer_tx_bit;
    // R10 local loop toward DTE
    // R14 loop inside processor
    // R19 pattern never to DTE
    wire dte_rd_next = (loop_reg != LOOP_M1) ? framer_rd_bit :
                       pat_active_reg ? 1'b1 : dte_td_bit;
    wire framer_rx_next = (loop_reg == LOOP_M1) ? 1'b1 : line_rx_bit;

    // R12 mode by link state
    // R15 mode 1 release stays in start-up
    // R17 mode 2 release keeps data mode
    assign loop_next = !loop_req ? LOOP_NONE :
                       (loop_rise && loop_reg == LOOP_NONE) ?
                       ((link_reg == LINK_DATA) ? LOOP_M2 : LOOP_M1) : loop_reg;
    assign link_next = restart_now ? LINK_STARTUP :
                       (frame_ok && loop_reg != LOOP_M1) ? LINK_DATA : link_reg;
    assign ctrl_next = wr_ctrl ? tlrs_ctrl_s'(hwdata[2:0]) : ctrl_reg;
    assign errcnt_next = det_err ? (errcnt_reg + 16'h0001) :
                         wr_errcnt ? ERRCNT_RST : errcnt_reg;

    // AHB-Lite slave: zero wait states, always OKAY.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= CTRL_RST;
            errcnt_reg <= ERRCNT_RST;
        end else begin
            wr_pend_reg <= wr_take;
            wr_addr_reg <= take_addr;
            if (rd_take) begin
                rdata_reg <= rd_mux;
            end
            ctrl_reg <= ctrl_next;
            errcnt_reg <= errcnt_next;
        end
    end

    // R23 one-second time base
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (tick_cnt_reg == TICK_CYCLES_P - 1);
            tick_cnt_reg <= (tick_cnt_reg == TICK_CYCLES_P - 1) ? 32'h0000_0000 :
                            tick_cnt_reg + 32'h0000_0001;
        end
    end

    // R4 consecutive unframed seconds
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            unfr_sec_reg <= 6'h00;
            restart_reg <= 1'b0;
            link_reg <= LINK_STARTUP;
            loop_reg <= LOOP_NONE;
            loop_req_d_reg <= 1'b0;
        end else begin
            restart_reg <= restart_now;
            link_reg <= link_next;
            loop_reg <= loop_next;
            loop_req_d_reg <= loop_req;
            if (frame_ok || restart_now) begin
                unfr_sec_reg <= 6'h00;
            end else if (tick_reg) begin
                unfr_sec_reg <= unfr_sec_reg + 6'h01;
            end
        end
    end

    // R6 pattern timeout
    // R7 blink until switch released
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pat_active_reg <= 1'b0;
            pat_timed_out_reg <= 1'b0;
            pat_sec_reg <= 6'h00;
            pat_req_d_reg <= 1'b0;
        end else begin
            pat_req_d_reg <= pat_req;
            if (pat_start) begin
                pat_active_reg <= 1'b1;
                pat_sec_reg <= 6'h00;
            end else if (!pat_req || loop_reg == LOOP_M2) begin
                pat_active_reg <= 1'b0;
            end else if (pat_active_reg && tick_reg) begin
                pat_sec_reg <= pat_sec_reg + 6'h01;
                if (pat_sec_reg == PAT_TIMEOUT_S - 6'h01) begin
                    pat_active_reg <= 1'b0;
                    pat_timed_out_reg <= 1'b1;
                end
            end
            if (!pat_req) begin
                pat_timed_out_reg <= 1'b0;
            end
        end
    end

    // Pattern generator and self-synchronising detector.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            gen_sr_reg <= PRBS_SEED;
            det_sr_reg <= 9'h000;
            det_fill_reg <= 4'h0;
        end else begin
            gen_sr_reg <= gen_next;
            det_sr_reg <= {det_sr_reg[7:0], det_in};
            if (!pat_active_reg) begin
                det_fill_reg <= 4'h0;
            end else if (det_fill_reg != 4'h9) begin
                det_fill_reg <= det_fill_reg + 4'h1;
            end
        end
    end

    // R21 error flash
    // R22 test-mode indicator
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_cnt_reg <= 32'h0000_0000;
            blink_reg <= 1'b0;
            err_ind_reg <= 1'b0;
            tm_reg <= 1'b0;
        end else begin
            if (flash_evt) begin
                flash_cnt_reg <= FLASH_CYCLES_P - 32'h0000_0001;
            end else if (flash_cnt_reg != 32'h0000_0000) begin
                flash_cnt_reg <= flash_cnt_reg - 32'h0000_0001;
            end
            if (tick_reg) begin
                blink_reg <= !blink_reg;
            end
            err_ind_reg <= pat_timed_out_reg ? blink_reg :
                           (flash_evt || flash_cnt_reg != 32'h0000_0000);
            tm_reg <= (loop_reg != LOOP_NONE) || pat_active_reg || pat_timed_out_reg ||
                      remote_digital_loop;
        end
    end

    // R1 framing drives CTS and CD
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cts_reg <= 1'b0;
            line_tx_reg <= 1'b1;
            dte_rd_reg <= 1'b1;
            framer_rx_reg <= 1'b1;
            fr_loop_reg <= 1'b0;
        end else begin
            cts_reg <= frame_ok;
            line_tx_reg <= line_tx_next;
            dte_rd_reg <= dte_rd_next;
            framer_rx_reg <= framer_rx_next;
            fr_loop_reg <= (loop_next == LOOP_M2);
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign line_tx_bit = line_tx_reg;
    assign dte_rd_bit = dte_rd_reg;
    assign framer_rx_bit = framer_rx_reg;
    assign framer_dte_loop = fr_loop_reg;
    assign cts = cts_reg;
    assign cd = cts_reg;
    assign line_restart = restart_reg;
    assign no_signal_indicator = (link_reg == LINK_STARTUP);
    assign error_indicator = err_ind_reg;
    assign test_mode_indicator = tm_reg;

    chk_cts_follows_frame: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
        frame_ok |=> (cts && cd)) else $error("cts or cd not raised after framed input");
    chk_cts_drops_unframed: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
        !frame_ok |=> (!cts && !cd)) else $error("cts or cd held without framing");
    chk_data_restart_4s: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
        (link_reg == LINK_DATA && !pat_active_reg && !remote_digital_loop && tick_reg &&
         !frame_ok && unfr_sec_reg == 6'h03) |=> (line_restart && no_signal_indicator))
        else $error("data mode did not restart at 4 s");
    chk_startup_restart_50s: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
        (line_restart && $past(link_reg) == LINK_STARTUP && !$past(pat_active_reg) &&
         !$past(remote_digital_loop)) |-> $past(unfr_sec_reg) == 6'h31)
        else $error("start-up restart not at 50 s");
    chk_pattern_restart_60s: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
        (line_restart && $past(pat_active_reg)) |-> $past(unfr_sec_reg) == 6'h3B)
        else $error("pattern restart not at 60 s");
    chk_rdl_restart_60s: assert property (@(posedge ref_clk) disable iff (!rst_b) // R8
        (line_restart && $past(remote_digital_loop)) |-> $past(unfr_sec_reg) == 6'h3B)
        else $error("remote-end restart not at 60 s");
    chk_pattern_stop_45s: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
        (pat_active_reg && pat_req && loop_reg != LOOP_M2 && tick_reg &&
         pat_sec_reg == 6'h2C) |=> (!pat_active_reg && pat_timed_out_reg))
        else $error("pattern did not stop at 45 s");
    chk_blink_until_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
        (pat_timed_out_reg && pat_req) |=> pat_timed_out_reg)
        else $error("timeout blink ended while pattern switch on");
    chk_mode2_no_gen: assert property (@(posedge ref_clk) disable iff (!rst_b) // R20
        (loop_reg == LOOP_M2) |=> !pat_active_reg) else $error("generator ran in mode 2");
    chk_mode1_dte_return: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
        (loop_reg == LOOP_M1 && !pat_active_reg) |=> (dte_rd_bit == $past(dte_td_bit)))
        else $error("mode 1 did not return DTE data");
    chk_remote_line_return: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
        remote_digital_loop |=> (line_tx_bit == $past(line_rx_bit)))
        else $error("remote loop did not return line data");
    chk_mode1_dte_blank: assert property (@(posedge ref_clk) disable iff (!rst_b) // R19
        (loop_reg == LOOP_M1 && pat_active_reg) |=> dte_rd_bit)
        else $error("pattern data reached the DTE");
    chk_pattern_on_line: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
        (pat_active_reg && loop_reg == LOOP_NONE && !remote_digital_loop) |=>
        (line_tx_bit == $past(gen_bit))) else $error("pattern not sent on the line");
    chk_loop_mode_pick: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
        (loop_rise && loop_reg == LOOP_NONE) |=>
        (loop_reg == (($past(link_reg) == LINK_DATA) ? LOOP_M2 : LOOP_M1)))
        else $error("wrong local loop mode chosen");

endmodule : tlrs_top

`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the test loop and restart supervisor.
// Assumes a one-second tick shortened to 20 cycles and a 3-cycle flash.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int T = 20;
    logic ref_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic frame_ok, crc_err, sw_local_loop, sw_pattern, dte_local_loop_req, dte_pattern_req;
    logic remote_digital_loop, dte_td_bit, framer_tx_bit, framer_rd_bit, line_rx_bit;
    logic line_tx_bit, dte_rd_bit, framer_rx_bit, framer_dte_loop, cts, cd, line_restart;
    logic no_signal_indicator, error_indicator, test_mode_indicator, framed, loop_far, crc_kick;
    int n_errors = 0;
    int tests_run = 0;
    assign hready = hreadyout;

    tlrs_top #(.TICK_CYCLES_P(T), .FLASH_CYCLES_P(3)) dut (.ref_clk, .rst_b, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .frame_ok,
        .crc_err, .sw_local_loop, .sw_pattern, .dte_local_loop_req, .dte_pattern_req,
        .remote_digital_loop, .dte_td_bit, .framer_tx_bit, .framer_rd_bit, .line_rx_bit,
        .line_tx_bit, .dte_rd_bit, .framer_rx_bit, .framer_dte_loop, .cts, .cd, .line_restart,
        .no_signal_indicator, .error_indicator, .test_mode_indicator);
    tlrs_peer_model peer (.ref_clk, .rst_b, .framed, .loop_far, .crc_kick, .line_tx_bit,
        .frame_ok, .crc_err, .line_rx_bit);

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic complete_run;
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic go(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : go

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask : ahb

    task automatic wait_restart(input int lo, input int hi);
        int n;
        n = 0;
        while (line_restart !== 1'b1 && n <= hi) begin
            go(1);
            n++;
        end
        chk(n >= lo && n <= hi, 1, "restart timing");
    endtask : wait_restart

    task automatic t_reset;
        go(15);
        chk({cts, cd, framer_dte_loop, line_restart, error_indicator, test_mode_indicator}, 0,
            "outputs in reset");
        chk({no_signal_indicator, line_tx_bit, dte_rd_bit, framer_rx_bit, hreadyout, hresp},
            6'b111110, "levels in reset");
        @(posedge ref_clk);
        rst_b <= 1'b1;
        ahb(1'b0, 32'h0000_0000, 0, d);
        chk(d, 0, "ctrl reset value");
        ahb(1'b0, 32'h0000_0008, 0, d);
        chk(d, 0, "error count reset value");
        ahb(1'b1, 32'h0000_0004, 32'hFFFF_FFFF, d);
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk(d, 0, "status is read only");
        ahb(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, d);
        ahb(1'b0, 32'h0000_000C, 0, d);
        chk(d, 0, "unmapped reads zero");
        $display("reset test done");
    endtask : t_reset

    task automatic t_loop1;
        @(posedge ref_clk);
        sw_local_loop <= 1'b1;
        dte_td_bit <= 1'b0;
        go(6);
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk(d[5:1], 5'b10001, "mode 1 with link down");
        chk(dte_rd_bit, 0, "local data looped");
        @(posedge ref_clk);
        dte_pattern_req <= 1'b1;
        go(60);
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk(d[3], 1, "pattern runs in mode 1");
        chk(dte_rd_bit, 1, "pattern kept from DTE");
        ahb(1'b0, 32'h0000_0008, 0, d);
        chk(d, 0, "looped pattern error free");
        ahb(1'b1, 32'h0000_0000, 32'h0000_0004, d);
        go(2 * T);
        ahb(1'b0, 32'h0000_0008, 0, d);
        chk(d != 0, 1, "injected errors counted");
        @(posedge ref_clk);
        dte_pattern_req <= 1'b0;
        sw_local_loop <= 1'b0;
        go(6);
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk({d[5:0], no_signal_indicator}, 1, "mode 1 released to start-up");
        $display("mode 1 test done");
    endtask : t_loop1

    task automatic t_link_loop2;
        int cnt;
        logic b;
        @(posedge ref_clk);
        framed <= 1'b1;
        go(4);
        chk({cts, cd, no_signal_indicator}, 3'b110, "framed link up");
        @(posedge ref_clk);
        dte_local_loop_req <= 1'b1;
        go(6);
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk({framer_dte_loop, d[2:0]}, 4'b1101, "mode 2 with link up");
        cnt = 0;
        repeat (10) begin
            b = line_tx_bit;
            go(1);
            cnt += (line_tx_bit !== b);
        end
        chk(cnt, 10, "far-end data returned to line");
        ahb(1'b1, 32'h0000_0000, 32'h0000_0002, d);
        ahb(1'b0, 32'h0000_0000, 0, d);
        chk(d, 2, "ctrl readback");
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk(d[3], 0, "no pattern in mode 2");
        ahb(1'b1, 32'h0000_0000, 0, d);
        @(posedge ref_clk);
        dte_local_loop_req <= 1'b0;
        go(6);
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk({framer_dte_loop, no_signal_indicator, line_tx_bit, d[2:0]}, 6'b001001,
            "mode 2 released to data");
        @(posedge ref_clk);
        crc_kick <= 1'b1;
        @(posedge ref_clk);
        crc_kick <= 1'b0;
        cnt = 0;
        repeat (8) begin
            go(1);
            cnt += (error_indicator === 1'b1);
        end
        chk(cnt, 3, "one flash per CRC error");
        $display("link and mode 2 test done");
    endtask : t_link_loop2

    task automatic t_restart;
        @(posedge ref_clk);
        framed <= 1'b0;
        wait_restart(3 * T, 4 * T + 3);
        chk({cts, cd, no_signal_indicator}, 3'b001, "unframed drops link");
        go(1);
        wait_restart(49 * T, 50 * T + 3);
        @(posedge ref_clk);
        framed <= 1'b1;
        go(5);
        @(posedge ref_clk);
        framed <= 1'b0;
        go(2 * T + 10);
        @(posedge ref_clk);
        framed <= 1'b1;
        @(posedge ref_clk);
        framed <= 1'b0;
        wait_restart(3 * T, 4 * T + 3);
        $display("restart test done");
    endtask : t_restart

    task automatic t_pattern;
        int cnt;
        logic b;
        @(posedge ref_clk);
        framed <= 1'b1;
        go(5);
        @(posedge ref_clk);
        sw_pattern <= 1'b1;
        framed <= 1'b0;
        cnt = 0;
        repeat (44 * T - 20) begin
            b = line_tx_bit;
            go(1);
            cnt += (line_tx_bit !== b);
            chk(line_restart, 0, "restart while pattern runs");
        end
        chk(cnt > 20, 1, "unframed pattern on line");
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk(d[4:3], 2'b01, "pattern still running");
        @(posedge ref_clk);
        framed <= 1'b1;
        go(2 * T + 25);
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk(d[4:3], 2'b10, "pattern timed out");
        cnt = 0;
        repeat (4 * T) begin
            b = error_indicator;
            go(1);
            cnt += (error_indicator !== b);
        end
        chk(cnt >= 3, 1, "blinks after timeout");
        ahb(1'b0, 32'h0000_0008, 0, d);
        chk(d == 0, 0, "bit errors counted");
        ahb(1'b1, 32'h0000_0008, 0, d);
        ahb(1'b0, 32'h0000_0008, 0, d);
        chk(d, 0, "error count cleared");
        @(posedge ref_clk);
        sw_pattern <= 1'b0;
        go(T + 5);
        cnt = 0;
        repeat (2 * T) begin
            go(1);
            cnt += (error_indicator !== 1'b0);
        end
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk({cnt[7:0], d[4:3]}, 0, "blink stops with switch");
        $display("pattern test done");
    endtask : t_pattern

    task automatic t_rdl;
        @(posedge ref_clk);
        remote_digital_loop <= 1'b1;
        framed <= 1'b0;
        wait_restart(59 * T, 60 * T + 3);
        chk(line_tx_bit ^ line_rx_bit, 1, "line data returned to line");
        ahb(1'b0, 32'h0000_0004, 0, d);
        chk({test_mode_indicator, d[6:5]}, 3'b111, "remote end in test mode");
        $display("remote loop test done");
    endtask : t_rdl

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        rst_b = 1'b0;
        {framed, loop_far, crc_kick, sw_local_loop, sw_pattern} = '0;
        {dte_local_loop_req, dte_pattern_req, remote_digital_loop} = '0;
        {dte_td_bit, framer_tx_bit, framer_rd_bit} = 3'b111;
        t_reset();
        t_loop1();
        t_link_loop2();
        t_restart();
        t_pattern();
        t_rdl();
        complete_run();
    end

    // The whole sequence needs about 3700 cycles; over five times that means a hang.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire

// File: test/tlrs_peer_model.sv
// Peer modem model on the far side of the line.
// Assumes the bench tells it when to send framed packets and when to loop the line back.
`timescale 1ns/1ps
`default_nettype none
module tlrs_peer_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic framed,
    input wire logic loop_far,
    input wire logic crc_kick,
    input wire logic line_tx_bit,
    output logic frame_ok,
    output logic crc_err,
    output logic line_rx_bit
);
    // Unlooped line data toggles every cycle, so a stuck value never passes for valid data.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_ok <= 1'b0;
            crc_err <= 1'b0;
            line_rx_bit <= 1'b1;
        end else begin
            frame_ok <= framed;
            crc_err <= crc_kick;
            line_rx_bit <= loop_far ? line_tx_bit : ~line_rx_bit;
        end
    end
endmodule : tlrs_peer_model
`default_nettype wire
